// >>> rtl/fps_seq.sv
// Purpose: Program command sequencer: word, buffered and factory buffered program.
// Assumes: Array engine on i_clk clears the zero bits of o_pgm_data at o_pgm_addr.
// Notes: Supply pins are synchronised; lock and region state come from same-clock logic.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fps_defs.svh"
module fps_seq #(
   parameter int AW = 26,
   parameter int BW = 9,
   parameter int BLKW = 17,
   parameter int FSETUP_CYC = `FPS_FSETUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [AW-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [15:0] o_rdata,
   input wire logic [15:0] i_array_rdata,
   input wire logic i_vpp_ok,
   input wire logic i_elevated_program_supply,
   input wire logic i_block_locked,
   input wire logic [1:0] i_region_mode,
   output logic o_pgm_req,
   output logic [AW-1:0] o_pgm_addr,
   output logic [15:0] o_pgm_data,
   input wire logic i_pgm_ack
);
   localparam int BD = 1 << BW;

   fps_pkg::fps_state_t st;
   fps_pkg::fps_rmode_t rmode [8];
   logic [15:0] bdat [BD];
   logic [AW-1:0] badr [BD];
   logic [BW-1:0] fill_idx;
   logic [BW-1:0] cnt;
   logic [BW-1:0] pidx;
   logic [AW-1:0] base;
   logic [15:0] sr;
   logic [15:0] sr_set;
   logic [15:0] status_w;
   logic [15:0] dly;
   logic susp;
   logic fetch;
   logic vs1, vs2, hs1, hs2;
   logic busy, fact, abort, same_blk, f_exit, f_misal;
   logic rd_cmd, last_word;
   logic [2:0] p_w, p_r, act_p;

   // The supply pins are asynchronous to i_clk; only the second stage is read.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         vs1 <= 1'b0;
         vs2 <= 1'b0;
         hs1 <= 1'b0;
         hs2 <= 1'b0;
      end else begin
         vs1 <= i_vpp_ok;
         vs2 <= vs1;
         hs1 <= i_elevated_program_supply;
         hs2 <= hs1;
      end
   end

   assign p_w = i_addr[AW-1 -: 3];
   assign p_r = i_addr[AW-1 -: 3];
   assign act_p = base[AW-1 -: 3];
   assign same_blk = (i_addr[AW-1:BLKW] == base[AW-1:BLKW]);
   assign busy = (st == fps_pkg::S_PROG) || fact;
   assign fact = (st == fps_pkg::S_FSETUP) || (st == fps_pkg::S_FFILL)
      || (st == fps_pkg::S_FPROG);
   assign rd_cmd = (i_wdata == `FPS_CMD_RD_ARR) || (i_wdata == `FPS_CMD_RD_INFO)
      || (i_wdata == `FPS_CMD_QUERY) || (i_wdata == `FPS_CMD_RD_STAT);
   assign f_exit = (fill_idx == '0) && (i_wdata == `FPS_PAD) && !same_blk; // RULE22
   assign f_misal = (i_addr[BW-1:0] != '0);
   assign last_word = (st == fps_pkg::S_PROG) ? (pidx == cnt) : (pidx == '1);

   // Start checks for a word or buffered program at address a.
   function automatic logic [15:0] start_err(input logic single, input logic [AW-1:0] a,
                                             input logic lock, input logic vok,
                                             input logic [1:0] reg_mode);
      logic [15:0] m;
      logic half;
      m = 16'h0000;
      half = a[`FPS_HALF_BIT];
      if (lock) begin
         m[`FPS_SR_LOCK] = 1'b1; // RULE3
         m[`FPS_SR_PERR] = 1'b1;
      end
      if (!vok) begin
         m[`FPS_SR_VPP] = 1'b1; // RULE3
         m[`FPS_SR_PERR] = 1'b1;
      end
      case (reg_mode)
         `FPS_REG_OBJ: begin
            m[`FPS_SR_PERR] = 1'b1; // RULE6
            m[`FPS_SR_OBJ] = 1'b1;
         end
         `FPS_REG_CTRL: begin
            if (half) begin
               m[`FPS_SR_PERR] = 1'b1; // RULE24
               m[`FPS_SR_HALF] = 1'b1;
               m[`FPS_SR_OBJ] = single;
            end
         end
         default: begin
            if (single && half) begin
               m[`FPS_SR_OBJ] = 1'b1; // RULE25
               m[`FPS_SR_HALF] = 1'b1;
            end
         end
      endcase
      return m;
   endfunction

   // Error events of this cycle; any of them ends the operation.
   always_comb begin
      sr_set = 16'h0000;
      case (st)
         fps_pkg::S_WDATA: begin
            if (i_we) begin
               sr_set = start_err(1'b1, i_addr, i_block_locked, vs2, i_region_mode); // RULE6
            end
         end
         fps_pkg::S_BCOUNT: begin
            if (i_we && (i_wdata > `FPS_MAX_CNT)) begin
               sr_set[`FPS_SR_SEQ] = 1'b1; // RULE14
               sr_set[`FPS_SR_PERR] = 1'b1;
            end
         end
         fps_pkg::S_BCONF: begin
            if (i_we && (i_wdata != `FPS_CMD_CONF)) begin
               sr_set[`FPS_SR_SEQ] = 1'b1; // RULE15
               sr_set[`FPS_SR_PERR] = 1'b1;
            end else if (i_we) begin
               sr_set = start_err(1'b0, base, i_block_locked, vs2, i_region_mode);
            end
         end
         fps_pkg::S_FCONF: begin
            if (i_we && (i_wdata != `FPS_CMD_CONF)) begin
               sr_set[`FPS_SR_SEQ] = 1'b1; // RULE2
               sr_set[`FPS_SR_PERR] = 1'b1;
            end
         end
         fps_pkg::S_FSETUP: begin
            if (dly == 16'(FSETUP_CYC - 1)) begin
               if (i_block_locked) begin
                  sr_set[`FPS_SR_LOCK] = 1'b1; // RULE18
                  sr_set[`FPS_SR_PERR] = 1'b1;
               end
               if (!hs2) begin
                  sr_set[`FPS_SR_VPP] = 1'b1; // RULE18
                  sr_set[`FPS_SR_PERR] = 1'b1;
               end
            end
         end
         fps_pkg::S_FFILL: begin
            if (!hs2) begin
               sr_set[`FPS_SR_VPP] = 1'b1; // RULE3
               sr_set[`FPS_SR_PERR] = 1'b1;
            end else if (i_we && !f_exit && f_misal) begin
               sr_set[`FPS_SR_PERR] = 1'b1; // RULE19
            end
         end
         fps_pkg::S_PROG: begin
            if (!vs2) begin
               sr_set[`FPS_SR_VPP] = 1'b1; // RULE3
               sr_set[`FPS_SR_PERR] = 1'b1;
            end
         end
         fps_pkg::S_FPROG: begin
            if (!hs2) begin
               sr_set[`FPS_SR_VPP] = 1'b1; // RULE3
               sr_set[`FPS_SR_PERR] = 1'b1;
            end
         end
         default: begin
            sr_set = 16'h0000;
         end
      endcase
   end

   // Any error event ends the operation, the upper-half word program included.
   assign abort = |sr_set;

   // Sequencer and array engine. A new setup is only taken when idle, so at most
   // one program runs; an erase suspended elsewhere does not block it.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= fps_pkg::S_IDLE; // RULE10
         base <= '0;
         cnt <= '0;
         fill_idx <= '0;
         pidx <= '0;
         fetch <= 1'b0;
         dly <= 16'h0000;
         o_pgm_req <= 1'b0;
         o_pgm_addr <= '0;
         o_pgm_data <= 16'h0000;
      end else if (abort) begin
         st <= fps_pkg::S_IDLE; // RULE3
         o_pgm_req <= 1'b0;
         fetch <= 1'b0;
      end else begin
         case (st)
            fps_pkg::S_IDLE: begin
               if (i_we) begin
                  base <= i_addr;
                  case (i_wdata)
                     `FPS_CMD_WORD: st <= fps_pkg::S_WDATA; // RULE1
                     `FPS_CMD_BUF: st <= fps_pkg::S_BCOUNT; // RULE2
                     `FPS_CMD_FACT: st <= fps_pkg::S_FCONF; // RULE2
                     default: st <= fps_pkg::S_IDLE;
                  endcase
               end
            end
            fps_pkg::S_WDATA: begin
               if (i_we) begin
                  base <= i_addr;
                  cnt <= '0;
                  pidx <= '0;
                  fetch <= 1'b1;
                  st <= fps_pkg::S_PROG;
               end
            end
            fps_pkg::S_BCOUNT: begin
               if (i_we) begin
                  cnt <= i_wdata[BW-1:0]; // RULE14
                  fill_idx <= '0;
                  st <= fps_pkg::S_BFILL;
               end
            end
            fps_pkg::S_BFILL: begin
               if (i_we) begin
                  fill_idx <= fill_idx + 1'b1;
                  if (fill_idx == cnt) begin
                     st <= fps_pkg::S_BCONF;
                  end
               end
            end
            fps_pkg::S_BCONF: begin
               if (i_we) begin
                  pidx <= '0; // RULE15
                  fetch <= 1'b1;
                  st <= fps_pkg::S_PROG;
               end
            end
            fps_pkg::S_FCONF: begin
               if (i_we) begin
                  dly <= 16'h0000;
                  st <= fps_pkg::S_FSETUP;
               end
            end
            fps_pkg::S_FSETUP: begin
               dly <= dly + 16'h0001;
               if (dly == 16'(FSETUP_CYC - 1)) begin
                  fill_idx <= '0; // RULE18
                  st <= fps_pkg::S_FFILL;
               end
            end
            fps_pkg::S_FFILL: begin
               if (i_we && f_exit) begin
                  st <= fps_pkg::S_IDLE; // RULE22
               end else if (i_we) begin
                  fill_idx <= fill_idx + 1'b1; // RULE20
                  if (fill_idx == '1) begin
                     pidx <= '0; // RULE21
                     fetch <= 1'b1;
                     st <= fps_pkg::S_FPROG;
                  end
               end
            end
            fps_pkg::S_PROG, fps_pkg::S_FPROG: begin
               // Suspend takes effect between words; factory mode ignores it.
               if (fetch && !susp) begin
                  fetch <= 1'b0;
                  o_pgm_req <= 1'b1;
                  o_pgm_data <= bdat[pidx]; // RULE1
                  if (st == fps_pkg::S_PROG) begin
                     o_pgm_addr <= badr[pidx];
                  end else begin
                     o_pgm_addr <= base + AW'(pidx); // RULE21
                  end
               end else if (o_pgm_req && i_pgm_ack) begin
                  o_pgm_req <= 1'b0;
                  if (!last_word) begin
                     pidx <= pidx + 1'b1;
                     fetch <= 1'b1;
                  end else if (st == fps_pkg::S_PROG) begin
                     st <= fps_pkg::S_IDLE; // RULE7
                  end else begin
                     base <= base + AW'(BD); // RULE21
                     fill_idx <= '0;
                     st <= fps_pkg::S_FFILL;
                  end
               end
            end
            default: st <= fps_pkg::S_IDLE;
         endcase
      end
   end

   // Write buffer; no reset, contents only matter between fill and program.
   always_ff @(posedge i_clk) begin
      if ((st == fps_pkg::S_WDATA) && i_we) begin
         bdat[0] <= i_wdata;
         badr[0] <= i_addr;
      end else if ((st == fps_pkg::S_BFILL) && i_we) begin
         bdat[fill_idx] <= i_wdata;
         badr[fill_idx] <= i_addr;
      end else if ((st == fps_pkg::S_FFILL) && i_we && !f_exit && !f_misal) begin
         bdat[fill_idx] <= i_wdata; // RULE20
      end
   end

   // Program suspend; resume reuses the confirm code.
   always_ff @(posedge i_clk) begin
      if (i_rst || (st != fps_pkg::S_PROG)) begin
         susp <= 1'b0;
      end else if (i_we && (i_wdata == `FPS_CMD_SUSP)) begin
         susp <= 1'b1; // RULE8
      end else if (i_we && susp && (i_wdata == `FPS_CMD_CONF)) begin
         susp <= 1'b0;
      end
   end

   // Error bits: a set in the same cycle as a clear wins.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sr <= 16'h0000;
      end else if ((st == fps_pkg::S_IDLE) && i_we && (i_wdata == `FPS_CMD_CLR_STAT)) begin
         sr <= sr_set;
      end else begin
         sr <= sr | sr_set;
      end
   end

   always_comb begin
      status_w = sr;
      status_w[`FPS_SR_READY] = !busy; // RULE7
      status_w[`FPS_SR_SUSP] = susp;
      status_w[`FPS_SR_BUFU] = (st == fps_pkg::S_FSETUP) || (st == fps_pkg::S_FPROG); // RULE21
   end

   // Per-partition read mode. In setup and factory states writes are data, not commands.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < 8; i++) begin
            rmode[i] <= fps_pkg::RM_ARRAY;
         end
      end else if (i_we && ((st == fps_pkg::S_IDLE) || (st == fps_pkg::S_PROG)) && rd_cmd) begin
         case (i_wdata)
            `FPS_CMD_RD_STAT: rmode[p_w] <= fps_pkg::RM_STATUS; // RULE5
            `FPS_CMD_RD_INFO: rmode[p_w] <= fps_pkg::RM_INFO;
            `FPS_CMD_QUERY: rmode[p_w] <= fps_pkg::RM_QUERY;
            default: rmode[p_w] <= fps_pkg::RM_ARRAY;
         endcase
      end else if (i_we && ((st == fps_pkg::S_WDATA) || (st == fps_pkg::S_BCONF)
                            || (st == fps_pkg::S_FCONF))) begin
         rmode[p_w] <= fps_pkg::RM_STATUS; // RULE4
      end
   end

   // Read port, data valid in the cycle after the strobe only.
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_re) begin
         o_rdata <= 16'h0000;
      end else if (rmode[p_r] == fps_pkg::RM_STATUS) begin
         o_rdata <= status_w;
      end else if (fact) begin
         o_rdata <= `FPS_INVALID; // RULE23
      end else if (busy && (p_r == act_p)) begin
         o_rdata <= `FPS_INVALID; // RULE9
      end else begin
         o_rdata <= i_array_rdata; // RULE16
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   word_setup_a: assert property ((st == fps_pkg::S_IDLE) && i_we && // RULE2
      (i_wdata == `FPS_CMD_WORD) |=> st == fps_pkg::S_WDATA)
      else $error("word setup not taken");
   lock_abort_a: assert property (i_we && i_block_locked && ((st == fps_pkg::S_WDATA) // RULE3
      || ((st == fps_pkg::S_BCONF) && (i_wdata == `FPS_CMD_CONF)))
      |=> (st == fps_pkg::S_IDLE) && sr[`FPS_SR_LOCK] && sr[`FPS_SR_PERR])
      else $error("locked block did not abort");
   word_status_a: assert property ((st == fps_pkg::S_WDATA) && i_we && (p_w == 3'h0) // RULE4
      |=> rmode[0] == fps_pkg::RM_STATUS)
      else $error("partition not in status mode");
   ready_done_a: assert property ((st == fps_pkg::S_PROG) && o_pgm_req && i_pgm_ack // RULE7
      && last_word && !abort |=> status_w[`FPS_SR_READY] ##1 status_w[`FPS_SR_READY])
      else $error("ready not shown after program");
   busy_clear_a: assert property ((st == fps_pkg::S_PROG) && i_we && vs2 && // RULE8
      (i_wdata == `FPS_CMD_CLR_STAT) |=> sr == $past(sr))
      else $error("clear status taken while busy");
   inval_read_a: assert property (i_re && (st == fps_pkg::S_PROG) && (p_r == act_p) // RULE9
      && (rmode[p_r] != fps_pkg::RM_STATUS) |=> o_rdata == `FPS_INVALID)
      else $error("busy partition read not invalid");
   reset_abort_a: assert property (@(posedge i_clk) disable iff (1'b0) i_rst // RULE10
      |=> (st == fps_pkg::S_IDLE) && !o_pgm_req)
      else $error("reset did not abort");
   count_range_a: assert property ((st == fps_pkg::S_BCOUNT) && i_we // RULE14
      && (i_wdata > `FPS_MAX_CNT) |=> (st == fps_pkg::S_IDLE) && sr[`FPS_SR_SEQ])
      else $error("bad count not aborted");
   confirm_only_a: assert property ((st == fps_pkg::S_BCONF) && i_we // RULE15
      && (i_wdata != `FPS_CMD_CONF) |=> (st == fps_pkg::S_IDLE) && sr[`FPS_SR_SEQ])
      else $error("missing confirm not aborted");
   fact_setup_a: assert property ((st == fps_pkg::S_FSETUP) && (dly == 16'(FSETUP_CYC - 1)) // RULE18
      && hs2 && vs2 && !i_block_locked |=> (st == fps_pkg::S_FFILL)
      && !status_w[`FPS_SR_READY] && !status_w[`FPS_SR_BUFU])
      else $error("factory setup did not reach fill");
   misalign_a: assert property ((st == fps_pkg::S_FFILL) && hs2 && i_we && !f_exit // RULE19
      && f_misal |=> (st == fps_pkg::S_IDLE) && sr[`FPS_SR_PERR])
      else $error("misaligned factory fill not aborted");
   fact_full_a: assert property ((st == fps_pkg::S_FFILL) && hs2 && i_we && !f_exit // RULE21
      && !f_misal && (fill_idx == '1) |=> (st == fps_pkg::S_FPROG) && status_w[`FPS_SR_BUFU])
      else $error("full buffer did not start programming");
   half_err_a: assert property ((st == fps_pkg::S_WDATA) && i_we && vs2 && !i_block_locked // RULE25
      && i_addr[`FPS_HALF_BIT] && (i_region_mode == `FPS_REG_ERASED)
      |=> sr[`FPS_SR_OBJ] && sr[`FPS_SR_HALF] && (st == fps_pkg::S_IDLE))
      else $error("upper half word program proceeded");

   word_done_c: cover property ((st == fps_pkg::S_PROG) ##[1:50] (st == fps_pkg::S_IDLE));
   buf_conf_c: cover property ((st == fps_pkg::S_BCONF) ##1 (st == fps_pkg::S_PROG));
   fact_exit_c: cover property ((st == fps_pkg::S_FFILL) && i_we && f_exit);
endmodule // fps_seq

// >>> common/fps_defs.svh
// Purpose: Constants for the flash program sequencer.
// Assumes: 16-bit command/data words, 100 MHz clock.
// Notes: Status bits are positions in the 16-bit status word.
// Function
// [RULE1] Programming only clears bits; one operation at a time; allowed in erase suspend.
// [RULE2] Word program 0041h+data; buffered E9h and factory 80h end with D0h.
// [RULE3] Locked block or bad program supply aborts and sets error bits.
// [RULE4] Word program switches the addressed partition to status reads until changed.
// [RULE5] Read status on another partition makes that partition show status.
// [RULE6] Word program only in control mode, lower half of the region.
// [RULE7] Ready bit is 0 while programming and 1 on completion.
// [RULE8] While programming only read commands and program suspend are taken.
// [RULE9] Non-status reads of the busy partition return invalid data.
// [RULE10] Reset aborts programming at once; location contents are then undefined.
// [RULE11] Host should start buffered programs on 32-word boundaries.
// [RULE12] Host aligns object-mode buffers to 512 words; control mode uses lower half.
// [RULE13] Host selects status mode and polls ready before a buffered program.
// [RULE14] Word count is words minus one, 0 to 1FFh; larger counts abort.
// [RULE15] Full buffer needs D0h confirm; anything else is a sequence error abort.
// [RULE16] Other partitions stay readable while a buffered program runs.
// [RULE17] Host checks and clears error bits after each program.
// [RULE18] Factory setup delay checks supply and lock; success shows ready and buffer at 0.
// [RULE19] Factory fill to a non-aligned address aborts with program error, buffer dropped.
// [RULE20] Factory fill goes to sequential buffer slots from 0; host pads with FFFFh.
// [RULE21] Factory programs when buffer full; buffer bit busy meanwhile; address advances.
// [RULE22] FFFFh written outside the block ends factory programming, ready goes 1.
// [RULE23] Factory programming is one block, not suspendable, no other-partition reads.
// [RULE24] Region is control mode if only lower half programmed, object mode otherwise.
// [RULE25] Word program to upper half of an erased region sets both mode error bits.
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
`define FPS_CMD_WORD 16'h0041
`define FPS_CMD_BUF 16'h00e9
`define FPS_CMD_FACT 16'h0080
`define FPS_CMD_CONF 16'h00d0
`define FPS_CMD_RD_ARR 16'h00ff
`define FPS_CMD_RD_INFO 16'h0090
`define FPS_CMD_QUERY 16'h0098
`define FPS_CMD_RD_STAT 16'h0070
`define FPS_CMD_CLR_STAT 16'h0050
`define FPS_CMD_SUSP 16'h00b0
`define FPS_PAD 16'hffff
`define FPS_MAX_CNT 16'h01ff
`define FPS_INVALID 16'h0000
`define FPS_SR_READY 7
`define FPS_SR_SEQ 5
`define FPS_SR_PERR 4
`define FPS_SR_VPP 3
`define FPS_SR_SUSP 2
`define FPS_SR_LOCK 1
`define FPS_SR_BUFU 0
`define FPS_SR_OBJ 8
`define FPS_SR_HALF 9
`define FPS_HALF_BIT 3
`define FPS_REG_ERASED 2'h0
`define FPS_REG_CTRL 2'h1
`define FPS_REG_OBJ 2'h2
`define FPS_CLK_NS 10
`define FPS_FSETUP_NS 1000
`define FPS_FSETUP_CYC ((`FPS_FSETUP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`endif

// >>> common/fps_pkg.sv
// Purpose: Types for the flash program sequencer.
// Assumes: Nothing beyond the constants header.
// Notes: Constants live in fps_defs.svh.
package fps_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_WDATA, S_BCOUNT, S_BFILL, S_BCONF, S_PROG,
      S_FCONF, S_FSETUP, S_FFILL, S_FPROG
   } fps_state_t;
   typedef enum logic [1:0] {
      RM_ARRAY, RM_INFO, RM_QUERY, RM_STATUS
   } fps_rmode_t;
endpackage

// >>> test/fps_engine_model.sv
// Purpose: Array engine model that takes program words from the sequencer.
// Assumes: One word at a time; the ack comes i_delay + 1 cycles after the request.
// Notes: A long delay keeps the sequencer busy so that status can be probed.
`timescale 1ns/1ps
module fps_engine_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [7:0] i_delay,
   output logic o_ack
);
   logic [7:0] wait_cnt;
   // The ack is one cycle long, so a held request is never taken twice.
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_req || o_ack) begin
         wait_cnt <= 8'h00;
         o_ack <= 1'b0;
      end else if (wait_cnt >= i_delay) begin
         o_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end
endmodule // fps_engine_model

// >>> test/flash_program_sequencer_tb.sv
// Purpose: Self-checking bench for the program sequencer.
// Assumes: Short factory setup delay; the engine model acks every word.
// Notes: Expected words wait in a queue and are compared as they are acked.
`timescale 1ns/1ps
`include "fps_defs.svh"
module flash_program_sequencer_tb;
   localparam logic [25:0] A = 26'h0000100;
   localparam logic [25:0] P2 = 26'h1000000;
   localparam logic [25:0] B = 26'h0020000;
   logic i_clk = 1'b0, i_rst = 1'b1, we = 1'b0, re = 1'b0, vok = 1'b1, eps = 1'b1;
   logic lock = 1'b0, ack, req;
   logic [25:0] addr = 26'h0000000, pa;
   logic [15:0] wd = 16'h0000, rdat, ard = 16'h0000, pd, got;
   logic [1:0] rmode = `FPS_REG_CTRL;
   logic [7:0] dly = 8'h00;
   logic [41:0] expq[$];
   int bad_count = 0, n_compared = 0, cyc = 0;
   fps_seq #(.FSETUP_CYC(4)) u_fps_seq (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr),
      .i_wdata(wd), .i_we(we), .i_re(re), .o_rdata(rdat), .i_array_rdata(ard),
      .i_vpp_ok(vok), .i_elevated_program_supply(eps), .i_block_locked(lock),
      .i_region_mode(rmode), .o_pgm_req(req), .o_pgm_addr(pa), .o_pgm_data(pd),
      .i_pgm_ack(ack));
   fps_engine_model u_fps_engine_model (.i_clk(i_clk), .i_rst(i_rst), .i_req(req),
      .i_delay(dly), .o_ack(ack));
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   task check(input string name, input logic [41:0] seen, input logic [41:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task bus_wr(input logic [25:0] a, input logic [15:0] d);
      @(posedge i_clk);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge i_clk);
      we <= 1'b0;
   endtask
   // A zero mask reads without comparing, for polling.
   task bus_rd(input logic [25:0] a, input logic [15:0] m, input logic [15:0] e,
               input string n);
      @(posedge i_clk);
      addr <= a;
      re <= 1'b1;
      @(posedge i_clk);
      re <= 1'b0;
      #1 got = rdat;
      if (m != 16'h0000) check(n, got & m, e);
   endtask
   task poll(input logic [25:0] a, input int b, input logic v, input string n);
      int k;
      k = 0;
      bus_rd(a, 16'h0000, 16'h0000, n);
      while (got[b] !== v && k < 3000) begin
         bus_rd(a, 16'h0000, 16'h0000, n);
         k++;
      end
      check(n, got[b], v);
   endtask
   always @(posedge i_clk) begin
      if (i_rst) expq.delete();
      else if (req === 1'b1 && ack === 1'b1) begin
         if (expq.size() == 0) check("unexpected word", 1, 0);
         else check("program word", {pa, pd}, expq.pop_front());
      end
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      int i, j, n;
      logic [15:0] d;
      void'($urandom(32'ha0da));
      ard = 16'($urandom);
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      bus_rd(A, 16'hffff, ard, "array read");
      // Slow engine keeps the word program busy while read modes change.
      dly <= 8'd90;
      d = 16'($urandom);
      expq.push_back({A, d});
      bus_wr(A, `FPS_CMD_WORD);
      bus_wr(A, d);
      bus_rd(A, 16'h0080, 16'h0000, "busy status");
      bus_wr(P2, `FPS_CMD_RD_STAT);
      bus_rd(P2, 16'h0080, 16'h0000, "other partition status");
      bus_wr(A, `FPS_CMD_SUSP);
      bus_rd(P2, 16'h0004, 16'h0004, "suspended");
      bus_wr(A, `FPS_CMD_CONF);
      bus_wr(A, `FPS_CMD_RD_ARR);
      bus_rd(A, 16'hffff, `FPS_INVALID, "busy array read");
      bus_wr(A, `FPS_CMD_RD_INFO);
      bus_rd(A, 16'hffff, `FPS_INVALID, "busy info read");
      bus_wr(A, `FPS_CMD_RD_STAT);
      poll(A, 7, 1'b1, "word ready");
      rmode <= `FPS_REG_ERASED;
      bus_wr(A | 26'h8, `FPS_CMD_WORD);
      bus_wr(A | 26'h8, 16'h0000);
      poll(A, 7, 1'b1, "half ready");
      bus_rd(A, 16'h0390, 16'h0380, "half errors");
      bus_wr(A, `FPS_CMD_CLR_STAT);
      rmode <= `FPS_REG_CTRL;
      for (i = 0; i < 2; i++) begin
         lock <= (i == 0);
         vok <= (i != 1);
         bus_wr(A, `FPS_CMD_WORD);
         bus_wr(A, 16'h0000);
         poll(A, 7, 1'b1, "abort ready");
         bus_rd(A, i ? 16'h0008 : 16'h0002, i ? 16'h0008 : 16'h0002, "abort error");
         lock <= 1'b0;
         vok <= 1'b1;
         bus_wr(A, `FPS_CMD_CLR_STAT);
      end
      bus_wr(A, `FPS_CMD_RD_STAT);
      poll(A, 7, 1'b1, "buffer available");
      dly <= 8'($urandom_range(0, 3));
      n = $urandom_range(1, 8);
      bus_wr(A, `FPS_CMD_BUF);
      bus_wr(A, 16'(n - 1));
      for (j = 0; j < n; j++) begin
         d = 16'($urandom);
         expq.push_back({26'(A + j), d});
         bus_wr(A + j, d);
      end
      bus_wr(A, `FPS_CMD_CONF);
      poll(A, 7, 1'b1, "buffered ready");
      check("buffered left", expq.size(), 0);
      bus_wr(A, `FPS_CMD_BUF);
      bus_wr(A, 16'h0200);
      poll(A, 7, 1'b1, "count abort ready");
      bus_wr(A, `FPS_CMD_BUF);
      bus_wr(A, 16'h0000);
      bus_wr(A, 16'h1234);
      bus_wr(A, `FPS_CMD_WORD);
      poll(A, 7, 1'b1, "confirm abort ready");
      bus_rd(A, 16'h00a0, 16'h00a0, "sequence error");
      bus_wr(A, `FPS_CMD_CLR_STAT);
      bus_wr(B, `FPS_CMD_FACT);
      bus_wr(B, `FPS_CMD_CONF);
      repeat (8) @(posedge i_clk);
      bus_rd(B, 16'h0081, 16'h0000, "factory setup");
      for (j = 0; j < 512; j++) begin
         d = 16'($urandom);
         expq.push_back({26'(B + j), d});
         bus_wr(B, d);
      end
      bus_rd(B, 16'h0001, 16'h0001, "buffer busy");
      poll(B, 0, 1'b0, "buffer free");
      check("factory left", expq.size(), 0);
      bus_wr(26'h0040000, `FPS_PAD);
      poll(B, 7, 1'b1, "factory exit");
      eps <= 1'b0;
      bus_wr(B, `FPS_CMD_FACT);
      bus_wr(B, `FPS_CMD_CONF);
      poll(B, 7, 1'b1, "supply abort ready");
      bus_rd(B, 16'h0018, 16'h0018, "factory supply");
      eps <= 1'b1;
      bus_wr(B, `FPS_CMD_CLR_STAT);
      bus_wr(B, `FPS_CMD_FACT);
      bus_wr(B, `FPS_CMD_CONF);
      repeat (8) @(posedge i_clk);
      bus_wr(B, 16'h0f0f);
      bus_wr(B + 26'h1, 16'h0f0f);
      poll(B, 7, 1'b1, "misaligned ready");
      bus_rd(B, 16'h0010, 16'h0010, "misaligned fail");
      dly <= 8'd200;
      bus_wr(A, `FPS_CMD_WORD);
      bus_wr(A, 16'h0000);
      bus_wr(A, `FPS_CMD_CLR_STAT);
      bus_rd(A, 16'h0090, 16'h0010, "clear while busy");
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      #1 check("request after reset", req, 0);
      bus_rd(A, 16'hffff, ard, "array after reset");
      stop_test();
   end
endmodule // flash_program_sequencer_tb
